// file: hdl/pao_axis.sv
// Axis pulse output with position override, trigger start and pin modes
// Operation
// - Reset clears registers to zero and drives pins high.
// - Rewriting target during a move changes destination from start point.
// - Farther target while accelerating or cruising keeps profile, ends there.
// - Farther target while decelerating re-accelerates toward high speed.
// - Passed or closer-in-decel target: stop, reverse, finish at target.
// - Rewrites accepted repeatedly until done; only while feeding.
// - Farther target after closer-target deceleration: no re-accelerate.
// - Ignored rewrite sets ignored flag; read of main status clears it.
// - Automatic ramp-down with long decel may overrun; user advice.
// - Target rewrites are rejected during interpolation.
// - Trigger mode counts programmed pulses from trigger input on.
// - Environment bit 24 sets trigger input polarity.
// - Extension status bit 8 shows trigger input state.
// - Command 28h acts as trigger input turning on.
// - Trigger overrides are rejected during interpolation.
// - Three-bit field picks pulse/direction, dual pulse or quadrature.
// - Dual pulse puts positive pulses on pulse pin, negative on dir.
// - Environment bit 28 low adds a 0.2 ms delay after direction change.
// - Slow rates give 4096-cycle pulses, faster ones near half duty.
// - Duty bit 13 forces near half duty at all rates.
// - Completion bit 0 ends operation at end of last cycle.
// - Completion bit 1 ends at pulse off, next start 15 cycles later.
//
// The address map and the strobed register port are this design's own decisions.
`default_nettype none
module pao_axis #(
	parameter int PW = 24,
	parameter int DIR_DELAY = pao_pkg::DIR_DELAY_CYC
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Register port
	input  wire logic [3:0]  regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [31:0] regRdata,
	// Trigger input and pins
	input  wire logic        positionTriggerInput,
	output logic             pulseOut,
	output logic             dirOut,
	output logic             errorClearOutput,
	output logic             axisBusy_n,
	output logic             writeRequest_n,
	output logic             interfaceBusy_n
);
	import pao_pkg::*;

	pao_state_t    state_r, state_nxt;
	logic [15:0]   opMode_r;
	logic [31:0]   env1_r;
	logic [PW-1:0] period_r;
	logic signed [31:0] target_r;    // target_amount_reg, relative to start
	logic signed [31:0] pos_r;       // pulses fed since start, signed
	logic          negDir_r;
	logic          ignoredFlag_r;
	logic          done_r;
	logic          armed_r;          // trigger mode waiting for the input
	logic          interp_r;
	logic [31:0]   regRdata_r;
	logic [15:0]   tmr_r;
	logic          trigPrev_r;
	logic          pgBusy, pgPulse;

	// Decode of register strobes
	wire wrTarget = regWr && regAddr == OFS_TARGET;
	wire wrOpMode = regWr && regAddr == OFS_OPMODE;
	wire wrEnv1   = regWr && regAddr == OFS_ENV1;
	wire wrCmd    = regWr && regAddr == OFS_COMMAND;
	wire wrPeriod = regWr && regAddr == OFS_PERIOD;
	wire wrCtrl   = regWr && regAddr == OFS_CTRL;
	wire rdMain   = regRd && regAddr == OFS_MAINSTS;

	// Trigger input after polarity, plus command substitute
	wire trigLevel = env1_r[ENV_PCSL] ? positionTriggerInput
	                                  : ~positionTriggerInput;
	wire trigEdge  = (trigLevel && !trigPrev_r)
	              || (wrCmd && regWdata[7:0] == CMD_TRIG_SUBST);
	wire feeding   = (state_r == ST_RUN) || (state_r == ST_DIRDL);
	// Start only from idle, so a start during the gap cannot clear position
	wire startReq  = wrCtrl && regWdata[CTL_START] && state_r == ST_IDLE;
	wire stopReq   = wrCtrl && regWdata[CTL_STOP];

	// Remaining distance and wanted direction
	wire signed [31:0] remain = target_r - pos_r;
	wire wantNeg  = remain < 0;
	wire atTarget = remain == 0;
	wire dirChange = wantNeg != negDir_r;
	wire metm     = opMode_r[OPM_METM];
	// Completion point: pulse off, or end of the whole cycle
	wire pulseEnd = metm ? !pgPulse : !pgBusy;

	// Override acceptance: only while feeding, never in interpolation
	wire ovrOk   = feeding && !interp_r;
	wire ovrMiss = wrTarget && !ovrOk;
	// Idle writes program the next move; refused overrides leave it alone
	wire takeTarget = wrTarget && (state_r == ST_IDLE || ovrOk);

	// Sequencer next state
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: begin
				if (startReq)
					state_nxt = (opMode_r[OPM_MPCS] && !regWdata[CTL_INTERP])
					          ? ST_WAIT
					          : ST_DIRDL;
			end
			ST_WAIT: begin
				if (stopReq)
					state_nxt = ST_IDLE;
				else if (trigEdge)
					state_nxt = ST_DIRDL;
			end
			ST_DIRDL: begin
				if (stopReq)
					state_nxt = ST_IDLE;
				else if (tmr_r == 16'h0000)
					state_nxt = ST_RUN;
			end
			ST_RUN: begin
				if (stopReq && !pgBusy)
					state_nxt = ST_IDLE;
				else if (pulseEnd && atTarget)
					state_nxt = metm ? ST_GAP : ST_IDLE;
				else if (!pgBusy && dirChange)
					state_nxt = ST_DIRDL;
			end
			ST_GAP: begin
				if (tmr_r == 16'h0000)
					state_nxt = ST_IDLE;
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	// Direction delay and gap timer
	wire [15:0] dirLoad = env1_r[ENV_DTMF] ? 16'h0000
	                    : 16'(DIR_DELAY);
	wire enterDir = state_nxt == ST_DIRDL && state_r != ST_DIRDL;
	wire enterGap = state_nxt == ST_GAP && state_r != ST_GAP;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tmr_r <= 16'h0000;
		end else if (enterDir) begin
			tmr_r <= dirChange || state_r == ST_IDLE || state_r == ST_WAIT
			       ? dirLoad : 16'h0000;
		end else if (enterGap) begin
			tmr_r <= 16'(PULSE_GAP_CYC - 1);
		end else if (tmr_r != 16'h0000) begin
			tmr_r <= tmr_r - 16'h0001;
		end
	end

	// Pulse issue: fire while running and short of target
	wire fire = state_r == ST_RUN && !atTarget && !dirChange && !stopReq;
	pao_pulse_gen #(.PW(PW)) u_pulse (
		.clk      (clk),
		.rst      (rst),
		.fire     (fire),
		.period   (period_r),
		.halfDuty (env1_r[ENV_PDTC]),
		.busy     (pgBusy),
		.pulseOn  (pgPulse)
	);
	wire issued = fire && !pgBusy;

	// Sequencer, position and direction
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r      <= ST_IDLE;
			pos_r        <= '0;
			negDir_r     <= 1'b0;
			trigPrev_r   <= 1'b0;
		end else begin
			state_r      <= state_nxt;
			trigPrev_r   <= trigLevel;
			if (startReq)
				pos_r <= '0;
			else if (issued)
				pos_r <= negDir_r ? pos_r - 1 : pos_r + 1;
			if (enterDir)
				negDir_r <= (startReq ? regWdata[31] : wantNeg);
		end
	end

	// Target, override and flags; set beats clear for the ignored flag
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			target_r <= '0;
			ignoredFlag_r <= 1'b0;
			done_r   <= 1'b0;
			armed_r  <= 1'b0;
		end else begin
			// New destination measured from start; speed profile upstream,
			// which also owns the overrun hazard of long decelerations
			if (takeTarget)
				target_r <= regWdata;
			if (ovrMiss)
				ignoredFlag_r <= 1'b1;
			else if (rdMain)
				ignoredFlag_r <= 1'b0;
			if (state_r != ST_IDLE && state_nxt == ST_IDLE)
				done_r <= 1'b1;
			else if (startReq)
				done_r <= 1'b0;
			armed_r <= state_nxt == ST_WAIT;
		end
	end

	// Configuration registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			opMode_r <= RST_WORD[15:0];
			env1_r   <= RST_WORD;
			period_r <= RST_WORD[PW-1:0];
			interp_r <= 1'b0;
		end else begin
			if (wrOpMode) opMode_r <= regWdata[15:0];
			if (wrEnv1)   env1_r   <= regWdata;
			if (wrPeriod) period_r <= regWdata[PW-1:0];
			if (wrCtrl)   interp_r <= regWdata[CTL_INTERP];
		end
	end

	// Read mux, data one cycle after the strobe
	wire [31:0] mainSts = {29'h0, done_r, ignoredFlag_r, state_r != ST_IDLE};
	wire [31:0] extSts  = {23'h0, trigLevel, 7'h0, armed_r};
	wire [31:0] rdMux   = regAddr == OFS_TARGET  ? target_r :
	                      regAddr == OFS_MAINSTS ? mainSts :
	                      regAddr == OFS_EXTSTS  ? extSts :
	                      regAddr == OFS_PERIOD  ? 32'(period_r) : 32'h0;
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			regRdata_r <= 32'h0000_0000;
		else
			regRdata_r <= regRd ? rdMux : 32'h0000_0000;
	end
	assign regRdata = regRdata_r;

	// Pin mapping
	pao_out_mode u_pins (
		.pulseOn  (pgPulse),
		.negDir   (negDir_r),
		.mode     (env1_r[ENV_PMD_LO +: 3]),
		.pulseOut (pulseOut),
		.dirOut   (dirOut)
	);
	assign errorClearOutput = 1'b1;
	assign axisBusy_n       = !(state_r != ST_IDLE);
	assign writeRequest_n   = 1'b1;
	assign interfaceBusy_n  = 1'b1;

	// Checks
	a_ignored_clear: assert property (@(posedge clk) disable iff (rst)
		rdMain && !ovrMiss |-> ##1 !ignoredFlag_r)
		else $error("ignored flag not cleared after main status read");
	a_ignored_set: assert property (@(posedge clk) disable iff (rst)
		ovrMiss |=> ignoredFlag_r)
		else $error("ignored flag not set on refused override");
	a_trig_wait: assert property (@(posedge clk) disable iff (rst)
		state_r == ST_WAIT && !trigEdge && !stopReq |=> state_r == ST_WAIT)
		else $error("trigger wait left without trigger");
	a_trig_go: assert property (@(posedge clk) disable iff (rst)
		state_r == ST_WAIT && trigEdge && !stopReq |=> state_r == ST_DIRDL)
		else $error("trigger did not start feed");
	a_gap_len: assert property (@(posedge clk) disable iff (rst)
		$rose(state_r == ST_GAP) |-> (state_r == ST_GAP)[*8] ##7 1)
		else $error("completion gap too short");
	a_dir_hold: assert property (@(posedge clk) disable iff (rst)
		pgBusy |-> $stable(negDir_r))
		else $error("direction changed during a pulse");
	a_trig_view: assert property (@(posedge clk) disable iff (rst)
		extSts[EXT_TRIG_STATE] == (env1_r[ENV_PCSL] ~^ positionTriggerInput))
		else $error("trigger state bit wrong");
	a_busy_pin: assert property (@(posedge clk) disable iff (rst)
		state_r == ST_RUN |-> !axisBusy_n)
		else $error("busy pin high while feeding");

	// Pins without logic of their own stay at their inactive level
	a_tie_high: assert property (@(posedge clk) disable iff (rst)
		errorClearOutput && writeRequest_n && interfaceBusy_n)
		else $error("tied pin not high");

	// Busy pin released whenever the sequencer rests
	a_busy_idle: assert property (@(posedge clk) disable iff (rst)
		state_r == ST_IDLE |-> axisBusy_n)
		else $error("busy pin low while idle");

	// Pulses only leave the timer while running
	a_no_fire: assert property (@(posedge clk) disable iff (rst)
		state_r != ST_RUN |-> !issued)
		else $error("pulse issued outside the run state");

	// A refused override must not move the destination
	a_target_hold: assert property (@(posedge clk) disable iff (rst)
		wrTarget && !takeTarget |=> $stable(target_r))
		else $error("refused override changed the target");

	// An accepted write lands as written
	a_target_take: assert property (@(posedge clk) disable iff (rst)
		takeTarget |=> target_r == $past(regWdata))
		else $error("accepted target write lost");

	// Interpolating starts never wait for the trigger
	a_interp_start: assert property (@(posedge clk) disable iff (rst)
		startReq && regWdata[CTL_INTERP] |=> state_r != ST_WAIT)
		else $error("trigger wait entered during interpolation");

	// With the delay switched off the direction state lasts one cycle
	a_dtmf_skip: assert property (@(posedge clk) disable iff (rst)
		state_r == ST_DIRDL && env1_r[ENV_DTMF] |=> state_r != ST_DIRDL)
		else $error("direction delay taken while switched off");

	// No pulse may overlap the direction settling time
	a_dirdl_quiet: assert property (@(posedge clk) disable iff (rst)
		state_r == ST_DIRDL |-> !pgPulse)
		else $error("pulse active during direction delay");

	// Every end of motion leaves the done flag set
	a_done_set: assert property (@(posedge clk) disable iff (rst)
		state_r != ST_IDLE && state_nxt == ST_IDLE |=> done_r)
		else $error("done flag not set at completion");

	// The gap opens only in pulse-off completion, with the pulse already off
	a_gap_entry: assert property (@(posedge clk) disable iff (rst)
		state_r == ST_RUN && state_nxt == ST_GAP |-> metm && !pgPulse)
		else $error("gap entered with pulse active");

	// Armed status mirrors the trigger wait
	a_armed_view: assert property (@(posedge clk) disable iff (rst)
		armed_r == (state_r == ST_WAIT))
		else $error("armed status out of step");

	// A reversal takes the sense that the remaining distance asks for
	a_reverse_dir: assert property (@(posedge clk) disable iff (rst)
		state_r == ST_RUN && state_nxt == ST_DIRDL
		|=> negDir_r == $past(wantNeg))
		else $error("reversal took the wrong direction");

	// Each issued pulse moves the position count
	a_pos_step: assert property (@(posedge clk) disable iff (rst)
		issued |=> pos_r != $past(pos_r))
		else $error("issued pulse not counted");
endmodule // pao_axis
`default_nettype wire

// file: hdl/pao_out_mode.sv
// Output pin mapping for the eight pulse output modes
`default_nettype none
module pao_out_mode (
	// Inputs
	input  wire logic       pulseOn,
	input  wire logic       negDir,
	input  wire logic [2:0] mode,
	// Pins, pulseOut idle high in modes 0, 2 and 4-6, dirOut in modes 4, 5 and 7
	output logic            pulseOut,
	output logic            dirOut
);
	wire act   = pulseOn;
	wire quadA = act ^ negDir;
	// Pulse plus direction modes 0-3, dual pulse 4-5, quadrature 6-7
	assign pulseOut = (mode[2:1] == 2'b10) ? ~(act & ~negDir) :
	                  (mode[2:1] == 2'b11) ? ~(mode[0] ? quadA : act) :
	                  (mode[0] ? act : ~act);
	assign dirOut   = (mode[2:1] == 2'b10) ? ~(act & negDir) :
	                  (mode[2:1] == 2'b11) ? ~(mode[0] ? act : quadA) :
	                  (mode[1] ? negDir : ~negDir);
endmodule // pao_out_mode
`default_nettype wire

// file: hdl/pao_pkg.sv
// Package: register map, field positions, codes and timing for the axis block
`default_nettype none
package pao_pkg;
	// Register offsets (word index on the plain port)
	localparam logic [3:0] OFS_TARGET   = 4'h0;
	localparam logic [3:0] OFS_OPMODE   = 4'h1;
	localparam logic [3:0] OFS_ENV1     = 4'h2;
	localparam logic [3:0] OFS_COMMAND  = 4'h3;
	localparam logic [3:0] OFS_MAINSTS  = 4'h4;
	localparam logic [3:0] OFS_EXTSTS   = 4'h5;
	localparam logic [3:0] OFS_PERIOD   = 4'h6;
	localparam logic [3:0] OFS_CTRL     = 4'h7;
	// Operation mode fields
	localparam int OPM_METM = 12;
	localparam int OPM_MPCS = 14;
	// Environment setting 1 fields
	localparam int ENV_PMD_LO = 0;
	localparam int ENV_PDTC   = 13;
	localparam int ENV_PCSL   = 24;
	localparam int ENV_DTMF   = 28;
	// Status fields
	localparam int EXT_TRIG_STATE = 8;
	localparam int MST_BUSY       = 0;
	localparam int MST_IGNORED    = 1;
	localparam int MST_DONE   = 2;
	// Control register fields
	localparam int CTL_START  = 0;
	localparam int CTL_STOP   = 1;
	localparam int CTL_INTERP = 2;
	// Command codes
	localparam logic [7:0] CMD_TRIG_SUBST = 8'h28;
	// Reset values
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	// Timing
	localparam int  CLK_HZ         = 40_000_000;
	localparam real DIR_DELAY_MS   = 0.2;
	localparam int  DIR_DELAY_CYC  = int'(DIR_DELAY_MS * CLK_HZ / 1000.0);
	localparam int  SLOW_PERIOD    = 8192;
	localparam int  FIXED_WIDTH    = 4096;
	localparam int  PULSE_GAP_CYC  = 15;
	// Pulse request from the sequencer to the output stage
	typedef struct packed {
		logic valid;
		logic negDir;
	} pao_step_t;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_WAIT  = 3'b001,
		ST_DIRDL = 3'b010,
		ST_RUN   = 3'b011,
		ST_GAP   = 3'b100
	} pao_state_t;
endpackage
`default_nettype wire

// file: hdl/pao_pulse_gen.sv
// Pulse timer: one pulse per period, width fixed or half period
`default_nettype none
module pao_pulse_gen #(
	parameter int PW = 24
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          rst,
	// Control
	input  wire logic          fire,
	input  wire logic [PW-1:0] period,
	input  wire logic          halfDuty,
	// Status
	output logic               busy,
	output logic               pulseOn
);
	import pao_pkg::*;
	logic [PW-1:0] cnt_r;
	logic [PW-1:0] width;
	wire           slowRate = period >= PW'(SLOW_PERIOD);
	// Slow rates keep a fixed width so the driver sees a clean edge
	assign width   = (slowRate && !halfDuty) ? PW'(FIXED_WIDTH)
	                                          : (period >> 1);
	assign busy    = cnt_r != '0;
	assign pulseOn = busy && (cnt_r > (period - width));
	// Period counter
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
		end else if (fire && !busy) begin
			cnt_r <= (period < PW'(2)) ? PW'(2) : period;
		end else if (busy) begin
			cnt_r <= cnt_r - PW'(1);
		end
	end
endmodule // pao_pulse_gen
`default_nettype wire

// file: verification/pao_drv_model.sv
// Driver model: counts steps from the pulse pins and times pulse width
`default_nettype none
module pao_drv_model (
	// Clock
	input  wire logic       clk,
	// Pins from the axis, pulseOut idle high in modes 0, 2 and 4-6, dirOut in modes 4, 5 and 7
	input  wire logic       pulseOut,
	input  wire logic       dirOut,
	// Output mode that the bench programmed
	input  wire logic [2:0] mode,
	// Net step count and last low time in cycles
	output var  int         pos,
	output var  int         width
);
	timeunit 1ns;
	timeprecision 100ps;
	logic pulsePrev = 1'b1;
	logic dirPrev   = 1'b1;
	int   lowCnt    = 0;
	initial pos = 0;
	initial width = 0;
	// A step is taken on a falling edge; dual modes step back on dirOut
	always @(posedge clk) begin
		pulsePrev <= pulseOut;
		dirPrev <= dirOut;
		lowCnt <= pulseOut ? 0 : lowCnt + 1;
		if (pulsePrev && !pulseOut)
			pos <= pos + ((mode[2] || dirOut) ? 1 : -1);
		if (mode[2] && dirPrev && !dirOut)
			pos <= pos - 1;
		if (!pulsePrev && pulseOut)
			width <= lowCnt;
	end
endmodule // pao_drv_model
`default_nettype wire

// file: verification/test_pulse_axis_override_output.sv
// Testbench for the axis block: register sequences and step counts
`default_nettype none
module test_pulse_axis_override_output;
	timeunit 1ns;
	timeprecision 100ps;
	import pao_pkg::*;
	// Short direction delay keeps the run brief
	localparam int DLY = 4;
	logic        clk      = 1'b0;
	logic        rst      = 1'b1;
	logic [3:0]  regAddr  = 4'h0;
	logic [31:0] regWdata = 32'h0000_0000;
	logic        regWr    = 1'b0;
	logic        regRd    = 1'b0;
	logic        trig     = 1'b1;
	logic [2:0]  outMode  = 3'h0;
	logic [31:0] regRdata;
	logic [31:0] r;
	logic        pulseOut, dirOut, errClr, busyN, wrReqN, ifBusyN;
	int          pos, width, p0, d, k;
	int          t[2];
	int          miscompares = 0;
	int          compares    = 0;
	always #12.5 clk = ~clk;
	pao_axis #(.DIR_DELAY(DLY)) dut (
		.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.positionTriggerInput(trig), .pulseOut(pulseOut), .dirOut(dirOut),
		.errorClearOutput(errClr), .axisBusy_n(busyN),
		.writeRequest_n(wrReqN), .interfaceBusy_n(ifBusyN)
	);
	pao_drv_model drv (
		.clk(clk), .pulseOut(pulseOut), .dirOut(dirOut), .mode(outMode),
		.pos(pos), .width(width)
	);
	// All idle-high pins packed for one compare
	function automatic logic [31:0] pins();
		return 32'({pulseOut, dirOut, errClr, busyN, wrReqN, ifBusyN});
	endfunction
	task automatic check(input string name, input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One-cycle strobes; a clock passes before the next access starts
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		regAddr <= a;
		regWdata <= v;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 v = regRdata;
		@(posedge clk);
	endtask
	// n<0: until idle, n=0: until a pulse starts, n>0: until n steps
	task automatic waitOn(input int n, output int c);
		c = 0;
		while ((n < 0 ? busyN !== 1'b1 : n == 0 ? pulseOut !== 1'b0 :
				pos - p0 < n) && c < 20000) begin
			@(negedge clk);
			c++;
		end
		@(posedge clk);
		if (c == 20000) begin
			miscompares++;
			results();
		end
	endtask
	// Start a move, optionally rewrite the target twice while feeding
	task automatic move(input logic [31:0] tgt, ctl, input int at,
			input logic [31:0] nt, input int at2, input logic [31:0] nt2);
		p0 = pos;
		wr(OFS_TARGET, tgt);
		wr(OFS_CTRL, ctl);
		// The idle target write flags itself; clear it before overrides
		rd(OFS_MAINSTS, r);
		if (at > 0) begin
			waitOn(at, k);
			wr(OFS_TARGET, nt);
		end
		if (at2 > 0) begin
			waitOn(at2, k);
			wr(OFS_TARGET, nt2);
		end
		waitOn(-1, k);
		d = pos - p0;
	endtask
	task automatic results();
		$display("Comparisons %0d, mismatches %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		// Reset state and an unmapped read
		check("pins", pins(), 32'h0000_003F);
		rd(OFS_MAINSTS, r);
		check("mainSts", r, 32'h0000_0000);
		rd(4'hF, r);
		check("unmapped", r, 32'h0000_0000);
		// Trigger state through both polarities
		wr(OFS_ENV1, 32'h1000_0000);
		wr(OFS_PERIOD, 32'h0000_0014);
		rd(OFS_EXTSTS, r);
		check("trigHighLow", r & 32'h100, 32'h0000_0000);
		trig <= 1'b0;
		rd(OFS_EXTSTS, r);
		check("trigLowLow", r & 32'h100, 32'h0000_0100);
		wr(OFS_ENV1, 32'h1100_0000);
		rd(OFS_EXTSTS, r);
		check("trigLowHigh", r & 32'h100, 32'h0000_0000);
		// Target written while idle sets the ignored flag; status read clears flag
		wr(OFS_TARGET, 32'h0000_0005);
		rd(OFS_MAINSTS, r);
		check("ignoredSet", r & 32'h2, 32'h0000_0002);
		repeat (3) @(posedge clk);
		rd(OFS_MAINSTS, r);
		check("ignoredClr", r & 32'h2, 32'h0000_0000);
		// Plain move, then farther rewrites, then a passed target
		move(32'h5, 32'h1, 0, 32'h0, 0, 32'h0);
		check("plainMove", 32'(d), 32'h0000_0005);
		check("halfDuty", 32'(width > 8 && width < 12), 32'h1);
		move(32'h6, 32'h1, 2, 32'h9, 4, 32'hC);
		check("farther", 32'(d), 32'h0000_000C);
		rd(OFS_MAINSTS, r);
		check("accepted", r & 32'h2, 32'h0000_0000);
		move(32'hA, 32'h1, 6, 32'h3, 0, 32'h0);
		check("reverse", 32'(d), 32'h0000_0003);
		// Rewrite refused while interpolating
		move(32'h6, 32'h5, 2, 32'h9, 0, 32'h0);
		check("interpMove", 32'(d), 32'h0000_0006);
		rd(OFS_MAINSTS, r);
		check("interpFlag", r & 32'h2, 32'h0000_0002);
		// Trigger mode: command first, then the input pin
		wr(OFS_OPMODE, 32'h0000_4000);
		for (int i = 0; i < 2; i++) begin
			wr(OFS_TARGET, 32'h0000_0004);
			wr(OFS_CTRL, 32'h0000_0001);
			repeat (40) @(posedge clk);
			p0 = pos;
			if (i == 0)
				wr(OFS_COMMAND, {24'h0, CMD_TRIG_SUBST});
			else
				trig <= 1'b1;
			waitOn(-1, k);
			check("trigMove", 32'(pos - p0), 32'h0000_0004);
		end
		trig <= 1'b0;
		// Completion at pulse off, followed by the start gap
		wr(OFS_OPMODE, 32'h0000_1000);
		move(32'h2, 32'h1, 0, 32'h0, 0, 32'h0);
		check("offComplete", 32'(d), 32'h0000_0002);
		wr(OFS_OPMODE, 32'h0000_0000);
		// Dual pulse mode in both directions
		wr(OFS_ENV1, 32'h1100_0004);
		outMode <= 3'h4;
		move(32'h3, 32'h1, 0, 32'h0, 0, 32'h0);
		check("dualPos", 32'(d), 32'h0000_0003);
		move(32'hFFFF_FFFD, 32'h8000_0001, 0, 32'h0, 0, 32'h0);
		check("dualNeg", 32'(d), 32'hFFFF_FFFD);
		// Start latency after a reversal, delay on and off
		outMode <= 3'h0;
		for (int i = 0; i < 2; i++) begin
			wr(OFS_ENV1, i ? 32'h1100_0000 : 32'h0100_0000);
			move(32'hFFFF_FFFF, 32'h8000_0001, 0, 32'h0, 0, 32'h0);
			wr(OFS_TARGET, 32'h0000_0001);
			wr(OFS_CTRL, 32'h0000_0001);
			waitOn(0, t[i]);
			waitOn(-1, k);
		end
		check("dirDelay", 32'(t[0] - t[1] >= DLY - 1), 32'h1);
		// Second reset in mid-move holds every pin idle
		wr(OFS_TARGET, 32'h0000_0014);
		wr(OFS_CTRL, 32'h0000_0001);
		p0 = pos;
		waitOn(3, k);
		rst <= 1'b1;
		repeat (8) @(posedge clk);
		check("pinsInReset", pins(), 32'h0000_003F);
		rst <= 1'b0;
		@(posedge clk);
		rd(OFS_MAINSTS, r);
		check("stsAfterReset", r, 32'h0000_0000);
		// Slow rate: fixed width, then forced half duty
		wr(OFS_ENV1, 32'h1100_0000);
		wr(OFS_PERIOD, 32'h0000_2008);
		move(32'h1, 32'h1, 0, 32'h0, 0, 32'h0);
		check("fixedWidth", 32'(width), 32'h0000_1000);
		wr(OFS_ENV1, 32'h1100_2000);
		move(32'h1, 32'h1, 0, 32'h0, 0, 32'h0);
		check("forcedDuty", 32'(width > 4089 && width < 4111), 32'h1);
		results();
	end
endmodule // test_pulse_axis_override_output
`default_nettype wire
